// File: hdl/iptfsm_input_train.v
/*
 * Input port link training state machine for an 8- or 16-bit
 * source-synchronous receive port.
 * Assumes the symbol decoder and sampling circuit run on clk and give
 * one classified symbol per cycle with a strobe; startTrain comes from
 * the device's init logic. Output machine state arrives as ok/idle
 * flags on clk.
 */
// Overview of operation
// R1 - train on leaving reset and whenever reliable sampling is lost
// R2 - port ready only when input and output machines are both operational
// R3 - detect receive errors only in operational or operational-retune states
// R4 - stay in reset while the start-training condition is false
// R5 - start-training condition moves reset to await-calibration
// R6 - await-calibration holds until the sampling circuit reports calibrated
// R7 - calibrated plus training pattern: go await-idle, request output idles
// R8 - a 16-bit port may downgrade its output to 8-bit on pattern
// R9 - in await-idle only patterns, idles and training requests are legal traffic
// R10 - idle in await-idle enters operational, ready for packets
// R11 - tolerate extra idle or pattern sequence at end of alignment
// R12 - unexpected symbol or lost calibration in await-idle restarts training
// R13 - stay operational while calibrated and not drifting
// R14 - drift while operational enters retune path before calibration lost
// R15 - calibration lost in operational restarts training, then error recovery
// R16 - retune state accepts traffic, reports errors, adjusts on patterns
// R17 - leave retune after 256 patterns then idle while still calibrated
// R18 - calibration lost in retune restarts training, then error recovery
// R19 - training request then pattern in operational goes to await-idle
// R20 - partner sends one training request then 256 patterns, looping
// R21 - packets pass only when both machines are operational
// R22 - drift uses retune state only if option present, else stay operational
// R23 - sampling circuit gives calibrated, drifting, pattern-seen each cycle
`timescale 1ns/10ps
`include "iptfsm_map.vh"

module iptfsm_input_train #(
    parameter RETUNE_EN = 1,
    parameter WIDE_PORT = 1
) (
    input wire clk,
    input wire nrst,
    input wire startTrain,
    input wire sampCalibrated,
    input wire sampDrift,
    input wire sampPttnSeen,
    input wire symValid,
    input wire [2:0] symClass,
    input wire outPortOk,
    input wire outPortIdleState,
    input wire downgradeReq,
    output reg [2:0] inState_r,
    output reg sendIdleReq_r,
    output reg restartTrain_r,
    output reg retuneReq_r,
    output reg sampAdjust_r,
    output reg portOk_r,
    output reg rxErrEn_r,
    output reg pktAccept_r,
    output reg narrowOut_r,
    output reg errRecovery_r
);

    // ------------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------------
    reg [2:0] state_nxt;
    reg [8:0] pttnCnt_r;
    reg [8:0] pttnCnt_nxt;
    reg trnReqSeen_r;
    reg trnReqSeen_nxt;
    reg recoverPend_r;
    reg recoverPend_nxt;

    wire isPttn = symValid && symClass == `IPT_SYM_PTTN;
    wire isIdle = symValid && symClass == `IPT_SYM_IDLE;
    wire isTrnReq = symValid && symClass == `IPT_SYM_TRN_REQ;
    wire isLegalTrn = isPttn || isIdle || isTrnReq; // R9 R11
    wire inOkStates = state_nxt == `IPT_ST_OK ||
                      state_nxt == `IPT_ST_OK_MT;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always @* begin
        state_nxt = inState_r;
        pttnCnt_nxt = pttnCnt_r;
        trnReqSeen_nxt = trnReqSeen_r;
        recoverPend_nxt = recoverPend_r;
        case (inState_r)
            `IPT_ST_RESET: begin
                if (startTrain) begin
                    state_nxt = `IPT_ST_WAIT_PTTN; // R5
                end else begin
                    state_nxt = `IPT_ST_RESET; // R4
                end
            end
            `IPT_ST_WAIT_PTTN: begin
                // R6 R23
                if (sampCalibrated && sampPttnSeen) begin
                    state_nxt = `IPT_ST_WAIT_IDLE; // R7
                end
            end
            `IPT_ST_WAIT_IDLE: begin
                if (!sampCalibrated ||
                        (symValid && !isLegalTrn)) begin
                    state_nxt = `IPT_ST_WAIT_PTTN; // R12
                end else if (isIdle) begin
                    state_nxt = `IPT_ST_OK; // R10
                end
            end
            `IPT_ST_OK: begin
                if (!sampCalibrated) begin
                    state_nxt = `IPT_ST_WAIT_PTTN; // R15
                    recoverPend_nxt = 1'b1;
                end else if (trnReqSeen_r && isPttn) begin
                    state_nxt = `IPT_ST_WAIT_IDLE; // R19
                end else if (sampDrift && RETUNE_EN != 0) begin
                    state_nxt = `IPT_ST_READY_MT; // R14 R22
                end
                // R13
                if (symValid) begin
                    trnReqSeen_nxt = isTrnReq;
                end
            end
            `IPT_ST_READY_MT: begin
                // ask the far end for a training run, then wait in retune
                pttnCnt_nxt = 9'h000;
                if (!sampCalibrated) begin
                    state_nxt = `IPT_ST_WAIT_PTTN; // R18
                    recoverPend_nxt = 1'b1;
                end else begin
                    state_nxt = `IPT_ST_OK_MT;
                end
            end
            `IPT_ST_OK_MT: begin
                if (!sampCalibrated) begin
                    state_nxt = `IPT_ST_WAIT_PTTN; // R18
                    recoverPend_nxt = 1'b1;
                end else if (isIdle && pttnCnt_r == `IPT_PTTN_COUNT) begin
                    state_nxt = `IPT_ST_OK; // R17
                end else if (isPttn) begin
                    if (pttnCnt_r != `IPT_PTTN_COUNT) begin
                        pttnCnt_nxt = pttnCnt_r + 9'h001;
                    end
                end else if (symValid) begin
                    // broken run: count again from the next pattern
                    pttnCnt_nxt = 9'h000;
                end
            end
            default: begin
                state_nxt = `IPT_ST_RESET;
            end
        endcase
        if (state_nxt != `IPT_ST_OK) begin
            trnReqSeen_nxt = 1'b0;
        end
        // recovery fires once on re-entry to operational
        if (state_nxt == `IPT_ST_OK && inState_r != `IPT_ST_OK) begin
            recoverPend_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            inState_r <= `IPT_ST_RESET; // R1
            pttnCnt_r <= 9'h000;
            trnReqSeen_r <= 1'b0;
            recoverPend_r <= 1'b0;
            sendIdleReq_r <= 1'b0;
            restartTrain_r <= 1'b0;
            retuneReq_r <= 1'b0;
            sampAdjust_r <= 1'b0;
            portOk_r <= 1'b0;
            rxErrEn_r <= 1'b0;
            pktAccept_r <= 1'b0;
            narrowOut_r <= 1'b0;
            errRecovery_r <= 1'b0;
        end else begin
            inState_r <= state_nxt;
            pttnCnt_r <= pttnCnt_nxt;
            trnReqSeen_r <= trnReqSeen_nxt;
            recoverPend_r <= recoverPend_nxt;
            sendIdleReq_r <= state_nxt == `IPT_ST_WAIT_IDLE; // R7
            // one-cycle pulse telling the output machine to start over
            restartTrain_r <= state_nxt == `IPT_ST_WAIT_PTTN &&
                              inState_r != `IPT_ST_WAIT_PTTN &&
                              inState_r != `IPT_ST_RESET; // R12 R15 R18
            retuneReq_r <= state_nxt == `IPT_ST_READY_MT; // R14
            sampAdjust_r <= inState_r == `IPT_ST_OK_MT && isPttn; // R16
            portOk_r <= inOkStates && outPortOk; // R2
            rxErrEn_r <= inOkStates; // R3 R16
            pktAccept_r <= inOkStates && outPortOk; // R21
            if (inState_r == `IPT_ST_WAIT_PTTN &&
                    state_nxt == `IPT_ST_WAIT_IDLE) begin
                narrowOut_r <= WIDE_PORT != 0 && downgradeReq; // R8
            end
            errRecovery_r <= recoverPend_r &&
                             state_nxt == `IPT_ST_OK; // R15 R18
        end
    end

endmodule

// File: hdl/iptfsm_map.vh
/*
 * Constants for the input port link training machine: state codes,
 * symbol class codes and the retune pattern count.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef IPTFSM_MAP_VH
`define IPTFSM_MAP_VH

// ----------------------------------------------------------------------
// input machine state codes
// ----------------------------------------------------------------------
`define IPT_ST_RESET     3'h0
`define IPT_ST_WAIT_PTTN 3'h1
`define IPT_ST_WAIT_IDLE 3'h2
`define IPT_ST_OK        3'h3
`define IPT_ST_READY_MT  3'h4
`define IPT_ST_OK_MT     3'h5

// ----------------------------------------------------------------------
// received symbol classes (from the symbol decoder)
// ----------------------------------------------------------------------
`define IPT_SYM_NONE     3'h0
`define IPT_SYM_PTTN     3'h1
`define IPT_SYM_IDLE     3'h2
`define IPT_SYM_TRN_REQ  3'h3
`define IPT_SYM_PACKET   3'h4
`define IPT_SYM_OTHER    3'h5

// ----------------------------------------------------------------------
// training run length during retune
// ----------------------------------------------------------------------
`define IPT_PTTN_COUNT   9'h100

`endif

// File: sim/iptfsm_far_port.sv
/* far-side output port model: training request, pattern run, idles.
   assumes clk is shared with the bench, which sets mode */
`timescale 1ns/10ps
`include "iptfsm_map.vh"
module iptfsm_far_port (
    input wire clk,
    input wire nrst,
    input wire [1:0] mode,
    output logic symValid,
    output logic [2:0] symClass
);
    logic [8:0] cnt;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 9'h0;
            symValid <= 1'b0;
            symClass <= 3'h0;
        end else begin
            symValid <= 1'b1;
            // mode 0 loops: one request, then the full pattern run
            if (mode == 2'h0 && cnt < `IPT_PTTN_COUNT) cnt <= cnt + 9'h1;
            else cnt <= 9'h0;
            case (mode)
            2'h0: symClass <= cnt == 9'h0 ? `IPT_SYM_TRN_REQ : `IPT_SYM_PTTN;
            2'h1: symClass <= `IPT_SYM_IDLE;
            default: symClass <= `IPT_SYM_PACKET;
            endcase
        end
    end
endmodule

// File: sim/iptfsm_input_train_chk.sv
/* checker for the input training machine.
   assumes bind onto the design top; same clock and reset */
`timescale 1ns/10ps
`include "iptfsm_map.vh"
module iptfsm_input_train_chk (
    input wire clk, nrst, startTrain, sampCalibrated, sampDrift, symValid,
    input wire sampPttnSeen, outPortOk, errRecovery_r,
    input wire [2:0] symClass, inState_r,
    input wire sendIdleReq_r, restartTrain_r, portOk_r, rxErrEn_r, pktAccept_r,
    input wire retuneReq_r, sampAdjust_r
);
    localparam [2:0] RS = `IPT_ST_RESET, CA = `IPT_ST_WAIT_PTTN;
    localparam [2:0] AI = `IPT_ST_WAIT_IDLE, OK = `IPT_ST_OK;
    localparam [2:0] RT = `IPT_ST_READY_MT, MT = `IPT_ST_OK_MT;
    wire okSt = inState_r == OK || inState_r == MT;
    wire badSym = symValid && symClass >= `IPT_SYM_PACKET;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    port_ok_a: assert property (portOk_r == (okSt && $past(outPortOk)))
        else $error("port ready out of step");
    err_gate_a: assert property (rxErrEn_r == okSt)
        else $error("error detection in training");
    pkt_gate_a: assert property (pktAccept_r == portOk_r)
        else $error("packet accept without ready");
    rst_hold_a: assert property (inState_r == RS && !startTrain |=>
        inState_r == RS) else $error("left reset early");
    train_go_a: assert property (inState_r == RS && startTrain |=>
        inState_r == CA) else $error("no training start");
    cal_wait_a: assert property (inState_r == CA && !sampCalibrated |=>
        inState_r == CA) else $error("left calibration wait");
    idle_req_a: assert property (inState_r == CA && sampCalibrated &&
        sampPttnSeen |=> inState_r == AI && sendIdleReq_r)
        else $error("no idle request");
    idle_ok_a: assert property (inState_r == AI && sampCalibrated && symValid
        && symClass == `IPT_SYM_IDLE |=> inState_r == OK)
        else $error("idle did not finish training");
    bad_sym_a: assert property (inState_r == AI && (!sampCalibrated || badSym)
        |=> inState_r == CA && restartTrain_r)
        else $error("await idle not restarted");
    drift_go_a: assert property (inState_r == OK && sampCalibrated && sampDrift
        && !(symValid && symClass == `IPT_SYM_PTTN)
        |=> inState_r == RT ##1 inState_r == MT)
        else $error("drift missed retune");
    cal_lost_a: assert property (okSt && !sampCalibrated |=>
        inState_r == CA && restartTrain_r)
        else $error("calibration loss not restarted");
    retune_req_a: assert property (retuneReq_r == (inState_r == RT))
        else $error("retune request out of step");
    samp_adj_a: assert property (sampAdjust_r == ($past(inState_r) == MT &&
        $past(symValid) && $past(symClass) == `IPT_SYM_PTTN))
        else $error("sampling adjust out of step");
    cover property (inState_r == MT ##1 inState_r == OK);
    cover property (inState_r == OK ##1 inState_r == AI);
    cover property (errRecovery_r);
endmodule
bind iptfsm_input_train iptfsm_input_train_chk chk (.*);

// File: sim/tb.sv
/* self-checking bench for the input training machine.
   assumes the far-port model supplies the received symbol stream */
`timescale 1ns/10ps
`include "iptfsm_map.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
    localparam [2:0] CA = `IPT_ST_WAIT_PTTN, AI = `IPT_ST_WAIT_IDLE;
    localparam [2:0] OK = `IPT_ST_OK, MT = `IPT_ST_OK_MT;
    logic clk = 0, nrst = 0, startTrain = 0, sampCalibrated = 0;
    logic sampDrift = 0, outPortOk = 0, downgradeReq = 0, symValid;
    logic [1:0] mode = 2'h2;
    logic [2:0] symClass, st;
    logic idleReq, portOk, errEn, narrow, errRec, sampPttnSeen;
    int failures = 0, compares = 0, cycles = 0;
    assign sampPttnSeen = symValid && symClass == `IPT_SYM_PTTN;
    iptfsm_far_port far (.clk(clk), .nrst(nrst), .mode(mode),
        .symValid(symValid), .symClass(symClass));
    iptfsm_input_train #(.RETUNE_EN(1), .WIDE_PORT(1)) DUT (.clk(clk),
        .nrst(nrst), .startTrain(startTrain), .sampCalibrated(sampCalibrated),
        .sampDrift(sampDrift), .sampPttnSeen(sampPttnSeen),
        .symValid(symValid), .symClass(symClass), .outPortOk(outPortOk),
        .outPortIdleState(1'b0), .downgradeReq(downgradeReq),
        .inState_r(st), .sendIdleReq_r(idleReq), .restartTrain_r(),
        .retuneReq_r(), .sampAdjust_r(), .portOk_r(portOk),
        .rxErrEn_r(errEn), .pktAccept_r(), .narrowOut_r(narrow),
        .errRecovery_r(errRec));
    initial forever #25 clk = ~clk;
    // run is under 400 cycles; ceiling leaves margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin failures++; close_out(); end
    end
    task close_out;
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task tick(input int n); repeat (n) @(posedge clk); #1; endtask
    task waitSt(input logic [2:0] s);
        for (int i = 0; i < 400 && st !== s; i++) tick(1);
        `CHK("state", s, st)
    endtask
    initial begin
        void'($urandom(5966));
        tick(3);
        @(posedge clk) nrst <= 1;
        tick(2 + $urandom % 5);
        `CHK("hold", `IPT_ST_RESET, st)
        @(posedge clk) startTrain <= 1;
        downgradeReq <= 1'($urandom);
        mode <= 2'h0;
        tick(1);
        `CHK("start", CA, st)
        tick(3 + $urandom % 20);
        `CHK("calwait", CA, st)
        @(posedge clk) sampCalibrated <= 1;
        waitSt(AI);
        `CHK("idlereq", 1'b1, idleReq)
        `CHK("narrow", downgradeReq, narrow)
        tick(1 + $urandom % 30);
        `CHK("tolerate", AI, st)
        @(posedge clk) mode <= 2'h1;
        outPortOk <= 1;
        waitSt(OK);
        `CHK("norecov", 1'b0, errRec)
        tick(1);
        `CHK("portok", 1'b1, portOk)
        `CHK("erren", 1'b1, errEn)
        repeat (8) begin
            @(posedge clk) outPortOk <= 1'($urandom);
            tick(2);
            `CHK("portok", outPortOk, portOk)
        end
        // drift, then exactly one request plus the full pattern run
        @(posedge clk) sampDrift <= 1;
        @(posedge clk) sampDrift <= 0;
        mode <= 2'h0;
        repeat (257) @(posedge clk);
        mode <= 2'h1;
        tick(2);
        `CHK("retuned", OK, st)
        @(posedge clk) mode <= 2'h0;
        tick(3);
        `CHK("reqpttn", AI, st)
        @(posedge clk) mode <= 2'h1;
        waitSt(OK);
        @(posedge clk) sampCalibrated <= 0;
        mode <= 2'h0;
        tick(2);
        `CHK("calloss", CA, st)
        `CHK("errdis", 1'b0, errEn)
        @(posedge clk) sampCalibrated <= 1;
        waitSt(AI);
        @(posedge clk) mode <= 2'h1;
        waitSt(OK);
        `CHK("recovery", 1'b1, errRec)
        @(posedge clk) mode <= 2'h0;
        waitSt(AI);
        @(posedge clk) mode <= 2'h2;
        tick(2);
        `CHK("badsym", CA, st)
        close_out();
    end
endmodule
